// file: hw/sfc_top.v
// serial flash command block: status writes, config register, plain and fast reads
// assumes spi pins arrive asynchronously; memory array answers on a valid/ready port
`timescale 1ns/1ps
`include "sfc_defines.vh"

module sfc_top #(
   parameter ADDR_W    = 24,
   parameter CNT_W     = 24,
   parameter WR_CYCLES = `SFC_WR_CYCLE_NS / `SFC_CLK_PERIOD_NS
) (
   input  wire              core_clk,
   input  wire              rst,
   input  wire              ce,
   input  wire              spi_clk,
   input  wire              spi_cs_n,
   input  wire [3:0]        dq_in,
   output reg  [3:0]        dq_out,
   output reg  [3:0]        dq_oe_n,
   input  wire              otp_mode,
   input  wire              ext_busy,
   output reg  [ADDR_W-1:0] mem_addr,
   output reg               mem_fetch,
   input  wire [7:0]        mem_data,
   input  wire              mem_data_valid,
   output wire              mem_data_ready,
   output wire [1:0]        cfg_wrap_len,
   output wire [1:0]        cfg_drive,
   output reg               four_line_cmd_mode,
   output reg               busy_cycle_flag,
   output reg               write_unlock_latch
);

   // -------------------------------------------------------------------------
   // states
   // -------------------------------------------------------------------------
   localparam [5:0] S_OPC   = 6'h01;
   localparam [5:0] S_ADDR  = 6'h02;
   localparam [5:0] S_DUMMY = 6'h04;
   localparam [5:0] S_DIN   = 6'h08;
   localparam [5:0] S_OUT   = 6'h10;
   localparam [5:0] S_SKIP  = 6'h20;
   localparam [31:0]      WR_LAST_W = WR_CYCLES - 1;
   localparam [CNT_W-1:0] WR_LAST   = WR_LAST_W[CNT_W-1:0];

   function [5:0] dummy_bytes;
      input [1:0] code;
      begin
         case (code)
            2'h0:    dummy_bytes = `SFC_DUMMY_CODE0;
            2'h1:    dummy_bytes = `SFC_DUMMY_CODE1;
            2'h2:    dummy_bytes = `SFC_DUMMY_CODE2;
            default: dummy_bytes = `SFC_DUMMY_CODE3;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------------
   // pin synchronisation and edge finding
   // -------------------------------------------------------------------------
   wire [5:0]  pins_s;
   wire        sclk_s;
   wire        cs_s;
   wire [3:0]  dq_s;
   reg         sclk_p_q;
   reg         cs_p_q;

   sfc_pin_sync #(.W(6)) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .d        ({spi_clk, spi_cs_n, dq_in}),
      .q        (pins_s)
   );

   assign sclk_s = pins_s[5];
   assign cs_s   = pins_s[4];
   assign dq_s   = pins_s[3:0];

   wire rise    = sclk_s & ~sclk_p_q & ~cs_s;
   wire fall    = ~sclk_s & sclk_p_q & ~cs_s;
   wire cs_rise = cs_s & ~cs_p_q;

   // -------------------------------------------------------------------------
   // registers and datapath
   // -------------------------------------------------------------------------
   reg [5:0]        state_q;
   reg [5:0]        cnt_q;
   reg [23:0]       sh_q;
   reg [7:0]        out_sh_q;
   reg [3:0]        obit_q;
   reg              src_stat_q;
   reg              stat_cfg_q;
   reg              tgt_cfg_q;
   reg              fast_q;
   reg              vol_en_q;
   reg [7:0]        nv_q;
   reg [7:0]        otp_q;
   reg [7:0]        sr3_q;
   reg [CNT_W-1:0]  wr_cnt_q;

   wire        buf_valid;
   wire [7:0]  buf_data;
   wire        buf_in_ready;
   wire        otp_locked = otp_mode & ~vol_en_q;
   wire [5:0]  step       = four_line_cmd_mode ? 6'h04 : 6'h01;
   wire [5:0]  cnt_nx     = cnt_q + step;
   wire [5:0]  cnt_one    = cnt_q + 6'h01;
   wire [23:0] sh_nx      = four_line_cmd_mode ? {sh_q[19:0], dq_s} : {sh_q[22:0], dq_s[0]};
   wire [7:0]  op         = sh_nx[7:0];
   wire        busy_any   = busy_cycle_flag | ext_busy;
   // protect pin shares dq2, so it only counts in single-line mode
   wire        pin_locked = nv_q[`SFC_SR1_GUARD] & ~dq_s[2] & ~four_line_cmd_mode
                            & ~otp_q[`SFC_OTP_PIN_DISABLE];
   wire [5:0]  dummy_clks = four_line_cmd_mode ?
                            (dummy_bytes(sr3_q[`SFC_SR3_DUMMY_MSB:`SFC_SR3_DUMMY_LSB])
                             << `SFC_QUAD_CLKS_PER_BYTE) :
                            `SFC_SPI_DUMMY_CLKS;
   wire [7:0]  sr1_rd     = {(otp_locked ? otp_q[7:2] : nv_q[7:2]),
                             write_unlock_latch, busy_any};
   wire [7:0]  sr3_rd     = sr3_q & `SFC_SR3_RW_MASK;
   wire        load_byte  = fall & (state_q == S_OUT) & (obit_q == 4'h0);
   wire        pop        = load_byte & ~src_stat_q & buf_valid;
   wire [7:0]  next_byte  = src_stat_q ? (stat_cfg_q ? sr3_rd : sr1_rd) :
                            (buf_valid ? buf_data : 8'hFF);
   wire        wr_ok      = write_unlock_latch & ~pin_locked & ~busy_any;
   wire        din_full   = (state_q == S_DIN) & (cnt_q == `SFC_DATA_BITS);
   wire [7:0]  boot_mask  = otp_q[`SFC_OTP_BOOT_LOCK] ? ~`SFC_SR1_BOOT_MASK : 8'hFF;
   wire [7:0]  nv_mask    = `SFC_SR1_WR_MASK & boot_mask;
   wire        fetch_take = mem_fetch & mem_data_valid & buf_in_ready;

   assign cfg_wrap_len = sr3_q[`SFC_SR3_WRAP_MSB:`SFC_SR3_WRAP_LSB];
   assign cfg_drive    = sr3_q[`SFC_SR3_DRIVE_MSB:`SFC_SR3_DRIVE_LSB];

   sfc_buf2 #(.W(8), .DEPTH(2), .AW(1)) u_buf (
      .core_clk  (core_clk),
      .rst       (rst),
      .ce        (ce),
      .flush     (cs_rise),
      .in_valid  (mem_fetch & mem_data_valid),
      .in_data   (mem_data),
      .in_ready  (buf_in_ready),
      .out_valid (buf_valid),
      .out_data  (buf_data),
      .out_ready (pop)
   );

   assign mem_data_ready = buf_in_ready;

   // -------------------------------------------------------------------------
   // command sequencer
   // -------------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (rst) begin
         sclk_p_q           <= 1'b0;
         cs_p_q             <= 1'b1;
         state_q            <= S_OPC;
         cnt_q              <= 6'h00;
         sh_q               <= 24'h000000;
         out_sh_q           <= 8'h00;
         obit_q             <= 4'h0;
         src_stat_q         <= 1'b0;
         stat_cfg_q         <= 1'b0;
         tgt_cfg_q          <= 1'b0;
         fast_q             <= 1'b0;
         vol_en_q           <= 1'b0;
         nv_q               <= `SFC_SR1_RESET;
         otp_q              <= `SFC_SR1_RESET;
         sr3_q              <= `SFC_SR3_RESET;
         wr_cnt_q           <= {CNT_W{1'b0}};
         dq_out             <= 4'h0;
         dq_oe_n            <= 4'hF;
         mem_addr           <= {ADDR_W{1'b0}};
         mem_fetch          <= 1'b0;
         four_line_cmd_mode <= 1'b0;
         busy_cycle_flag    <= 1'b0;
         write_unlock_latch <= 1'b0;
      end else if (ce) begin
         sclk_p_q <= sclk_s;
         cs_p_q   <= cs_s;

         // timed status write cycle
         if (busy_cycle_flag) begin
            if (wr_cnt_q == {CNT_W{1'b0}}) begin
               busy_cycle_flag    <= 1'b0;
               write_unlock_latch <= 1'b0;
            end else begin
               wr_cnt_q <= wr_cnt_q - 1'b1;
            end
         end

         if (fetch_take)
            mem_addr <= mem_addr + 1'b1;

         if (cs_rise) begin
            // end of frame: drop the lines and commit a write only if its data byte arrived whole
            state_q   <= S_OPC;
            cnt_q     <= 6'h00;
            obit_q    <= 4'h0;
            mem_fetch <= 1'b0;
            dq_oe_n   <= 4'hF;
            if (din_full & tgt_cfg_q) begin
               sr3_q <= sh_q[7:0] & `SFC_SR3_RW_MASK;
            end else if (din_full & wr_ok) begin
               if (otp_locked)
                  otp_q <= otp_q | (sh_q[7:0] & `SFC_OTP_WR_MASK);
               else
                  nv_q <= (nv_q & ~nv_mask) | (sh_q[7:0] & nv_mask);
               busy_cycle_flag <= 1'b1;
               wr_cnt_q        <= WR_LAST;
            end
         end else begin
            case (state_q)
               S_OPC: begin
                  if (rise) begin
                     sh_q  <= sh_nx;
                     cnt_q <= cnt_nx;
                     if (cnt_nx == `SFC_OPC_BITS) begin
                        cnt_q <= 6'h00;
                        case (op)
                           `SFC_OP_WRITE_UNLOCK: begin
                              if (!busy_any)
                                 write_unlock_latch <= 1'b1;
                              state_q <= S_SKIP;
                           end
                           `SFC_OP_WRITE_LOCK: begin
                              if (!busy_any)
                                 write_unlock_latch <= 1'b0;
                              state_q <= S_SKIP;
                           end
                           `SFC_OP_STATUS1_FETCH: begin
                              src_stat_q <= 1'b1;
                              stat_cfg_q <= 1'b0;
                              state_q    <= S_OUT;
                           end
                           `SFC_OP_CONFIG_FETCH: begin
                              src_stat_q <= 1'b1;
                              stat_cfg_q <= 1'b1;
                              state_q    <= S_OUT;
                           end
                           `SFC_OP_STATUS_WRITE: begin
                              tgt_cfg_q <= 1'b0;
                              state_q   <= wr_ok ? S_DIN : S_SKIP;
                           end
                           `SFC_OP_CONFIG_WRITE: begin
                              tgt_cfg_q <= 1'b1;
                              state_q   <= S_DIN;
                           end
                           `SFC_OP_READ, `SFC_OP_FAST_READ: begin
                              fast_q     <= (op == `SFC_OP_FAST_READ);
                              src_stat_q <= 1'b0;
                              state_q    <= busy_any ? S_SKIP : S_ADDR;
                           end
                           `SFC_OP_FOUR_LINE_ENTRY: begin
                              four_line_cmd_mode <= 1'b1;
                              state_q            <= S_SKIP;
                           end
                           `SFC_OP_FOUR_LINE_EXIT: begin
                              four_line_cmd_mode <= 1'b0;
                              state_q            <= S_SKIP;
                           end
                           `SFC_OP_VOLATILE_EN: begin
                              vol_en_q <= 1'b1;
                              state_q  <= S_SKIP;
                           end
                           default: state_q <= S_SKIP;
                        endcase
                     end
                  end
               end
               S_ADDR: begin
                  if (rise) begin
                     sh_q  <= sh_nx;
                     cnt_q <= cnt_nx;
                     if (cnt_nx == `SFC_ADDR_BITS) begin
                        cnt_q     <= 6'h00;
                        mem_addr  <= sh_nx[ADDR_W-1:0];
                        mem_fetch <= 1'b1;
                        state_q   <= fast_q ? S_DUMMY : S_OUT;
                     end
                  end
               end
               S_DUMMY: begin
                  if (rise) begin
                     cnt_q <= cnt_one;
                     if (cnt_one == dummy_clks)
                        state_q <= S_OUT;
                  end
               end
               S_DIN: begin
                  if (rise) begin
                     sh_q <= sh_nx;
                     if (cnt_q == `SFC_DATA_BITS)
                        state_q <= S_SKIP;
                     else
                        cnt_q <= cnt_nx;
                  end
               end
               S_OUT: begin
                  if (fall) begin
                     dq_oe_n <= four_line_cmd_mode ? 4'h0 : 4'hD;
                     if (obit_q == 4'h0) begin
                        if (four_line_cmd_mode) begin
                           dq_out   <= next_byte[7:4];
                           out_sh_q <= {next_byte[3:0], 4'h0};
                        end else begin
                           dq_out   <= {2'b00, next_byte[7], 1'b0};
                           out_sh_q <= {next_byte[6:0], 1'b0};
                        end
                        obit_q <= `SFC_BYTE_BITS - step[3:0];
                     end else begin
                        if (four_line_cmd_mode) begin
                           dq_out   <= out_sh_q[7:4];
                           out_sh_q <= {out_sh_q[3:0], 4'h0};
                        end else begin
                           dq_out   <= {2'b00, out_sh_q[7], 1'b0};
                           out_sh_q <= {out_sh_q[6:0], 1'b0};
                        end
                        obit_q <= obit_q - step[3:0];
                     end
                  end
               end
               S_SKIP: begin
                  state_q <= S_SKIP;
               end
               default: state_q <= S_OPC;
            endcase
         end
      end
   end

endmodule

// file: hw/sfc_defines.vh
// constants for the serial flash command block: opcodes, status fields, phase lengths
// assumes inclusion by the design files only; holds definitions and no logic
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH

// ----------------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------------
`define SFC_OP_STATUS_WRITE   8'h01
`define SFC_OP_READ           8'h03
`define SFC_OP_WRITE_LOCK     8'h04
`define SFC_OP_STATUS1_FETCH  8'h05
`define SFC_OP_WRITE_UNLOCK   8'h06
`define SFC_OP_FAST_READ      8'h0B
`define SFC_OP_FOUR_LINE_ENTRY 8'h38
`define SFC_OP_VOLATILE_EN    8'h50
`define SFC_OP_CONFIG_FETCH   8'h95
`define SFC_OP_CONFIG_WRITE   8'hC0
`define SFC_OP_FOUR_LINE_EXIT 8'hFF

// ----------------------------------------------------------------------------
// first status register layout
// ----------------------------------------------------------------------------
`define SFC_SR1_BUSY         0
`define SFC_SR1_LATCH        1
`define SFC_SR1_TOP_BOTTOM   3
`define SFC_SR1_SECTOR_GRAN  4
`define SFC_SR1_GUARD        7
`define SFC_SR1_WR_MASK      8'hFC
`define SFC_SR1_BOOT_MASK    8'h18
`define SFC_OTP_WR_MASK      8'hDC
`define SFC_OTP_BOOT_LOCK    3
`define SFC_OTP_PIN_DISABLE  6
`define SFC_SR1_RESET        8'h00

// ----------------------------------------------------------------------------
// read_config_status layout
// ----------------------------------------------------------------------------
`define SFC_SR3_WRAP_MSB     1
`define SFC_SR3_WRAP_LSB     0
`define SFC_SR3_DRIVE_MSB    3
`define SFC_SR3_DRIVE_LSB    2
`define SFC_SR3_DUMMY_MSB    5
`define SFC_SR3_DUMMY_LSB    4
`define SFC_SR3_RW_MASK      8'h3F
`define SFC_SR3_RESET        8'h00

// ----------------------------------------------------------------------------
// dummy byte counts for reads without wrap, by code
// ----------------------------------------------------------------------------
`define SFC_DUMMY_CODE0      6'h03
`define SFC_DUMMY_CODE1      6'h02
`define SFC_DUMMY_CODE2      6'h04
`define SFC_DUMMY_CODE3      6'h05
`define SFC_QUAD_CLKS_PER_BYTE 1
`define SFC_SPI_DUMMY_CLKS   6'h08

// ----------------------------------------------------------------------------
// phase lengths in bits and timing
// ----------------------------------------------------------------------------
`define SFC_OPC_BITS         6'h08
`define SFC_ADDR_BITS        6'h18
`define SFC_DATA_BITS        6'h08
`define SFC_BYTE_BITS        4'h8
`define SFC_CLK_PERIOD_NS    40
`define SFC_WR_CYCLE_NS      5000000

`endif

// file: hw/sfc_pin_sync.v
// two-stage synchroniser for pins arriving from outside the core clock domain
// assumes core_clk is free running; ce freezes the stages
`timescale 1ns/1ps

module sfc_pin_sync #(
   parameter W = 1
) (
   input  wire         core_clk,
   input  wire         rst,
   input  wire         ce,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge core_clk) begin
      if (rst) begin
         meta_q <= {W{1'b1}};
         sync_q <= {W{1'b1}};
      end else if (ce) begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule

// file: hw/sfc_buf2.v
// small fifo between the memory fetch port and the output shifter
// assumes one clock domain; flush empties it in one cycle
`timescale 1ns/1ps

module sfc_buf2 #(
   parameter W     = 8,
   parameter DEPTH = 2,
   parameter AW    = 1
) (
   input  wire         core_clk,
   input  wire         rst,
   input  wire         ce,
   input  wire         flush,
   input  wire         in_valid,
   input  wire [W-1:0] in_data,
   output wire         in_ready,
   output wire         out_valid,
   output wire [W-1:0] out_data,
   input  wire         out_ready
);

   reg [W-1:0]  mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0]   cnt_q;
   reg [AW:0]   cnt_d;
   reg          ready_q;
   wire         push;
   wire         pop;

   assign push      = in_valid & ready_q;
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_q[rd_ptr_q];
   assign in_ready  = ready_q;

   always @* begin
      cnt_d = cnt_q;
      if (push & ~pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop & ~push)
         cnt_d = cnt_q - 1'b1;
   end

   always @(posedge core_clk) begin
      if (rst) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         cnt_q    <= {(AW+1){1'b0}};
         ready_q  <= 1'b0;
      end else if (ce) begin
         if (flush) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            cnt_q    <= {(AW+1){1'b0}};
            ready_q  <= 1'b1;
         end else begin
            if (push) begin
               mem_q[wr_ptr_q] <= in_data;
               wr_ptr_q        <= (wr_ptr_q == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop)
               rd_ptr_q <= (rd_ptr_q == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            cnt_q   <= cnt_d;
            ready_q <= (cnt_d != DEPTH);
         end
      end
   end

endmodule

// file: tb/sfc_props.sv
// timing checks on the serial flash command block's ports
// assumes one core clock domain and the synchronous active-high reset
`timescale 1ns/1ps
module sfc_props #(
   parameter ADDR_W    = 24,
   parameter WR_CYCLES = 20
) (
   input wire              core_clk,
   input wire              rst,
   input wire              spi_cs_n,
   input wire [3:0]        dq_oe_n,
   input wire [ADDR_W-1:0] mem_addr,
   input wire              mem_fetch,
   input wire              mem_data_valid,
   input wire              mem_data_ready,
   input wire              four_line_cmd_mode,
   input wire              busy_cycle_flag,
   input wire              write_unlock_latch
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [31:0] bcnt_q;
   logic [31:0] bcnt_d;
   // ----------------------------------------------------------------------------
   // busy length counter
   // ----------------------------------------------------------------------------
   assign bcnt_d = busy_cycle_flag ? bcnt_q + 32'h1 : 32'h0;
   always @(posedge core_clk) bcnt_q <= rst ? 32'h0 : bcnt_d;
   sequence s_take;
      mem_fetch && mem_data_valid && mem_data_ready;
   endsequence
   sequence s_cs_up;
      $rose(spi_cs_n);
   endsequence
   a_busy_span: assert property ($fell(busy_cycle_flag) |-> bcnt_q == WR_CYCLES)
      else $error("busy cycle length wrong");
   a_latch_clear: assert property ($fell(busy_cycle_flag) |-> !write_unlock_latch)
      else $error("unlock latch kept after cycle");
   a_needs_latch: assert property ($rose(busy_cycle_flag) |-> $past(write_unlock_latch))
      else $error("write cycle without unlock latch");
   a_no_fetch_busy: assert property ($rose(mem_fetch) |-> !busy_cycle_flag)
      else $error("read started during write cycle");
   a_addr_step: assert property (s_take ##1 mem_fetch |-> mem_addr == $past(mem_addr) + 1'b1)
      else $error("address did not advance by one");
   a_stop_drive: assert property (s_cs_up |-> ##[1:5] dq_oe_n == 4'hF)
      else $error("data lines not released");
   a_stop_fetch: assert property (s_cs_up |-> ##[1:5] !mem_fetch)
      else $error("fetch kept after deselect");
   a_oe_single: assert property (!four_line_cmd_mode |-> dq_oe_n == 4'hF || dq_oe_n == 4'hD)
      else $error("wrong lines driven in single-line mode");
endmodule
bind sfc_top sfc_props #(.ADDR_W(ADDR_W), .WR_CYCLES(WR_CYCLES)) i_props (
   .core_clk(core_clk), .rst(rst), .spi_cs_n(spi_cs_n), .dq_oe_n(dq_oe_n),
   .mem_addr(mem_addr), .mem_fetch(mem_fetch), .mem_data_valid(mem_data_valid),
   .mem_data_ready(mem_data_ready), .four_line_cmd_mode(four_line_cmd_mode),
   .busy_cycle_flag(busy_cycle_flag), .write_unlock_latch(write_unlock_latch));

// file: tb/sfc_host_model.sv
// host controller model: single- or four-line frames, 320 ns serial clock, mode 0
// assumes its task is entered on a falling core clock edge
`timescale 1ns/1ps
module sfc_host_model (
   output reg        spi_clk,
   output reg        spi_cs_n,
   output reg  [3:0] dq_in,
   output reg        drove,
   input  wire [3:0] dq_out,
   input  wire [3:0] dq_oe_n
);
   logic             quad = 1'b0;
   initial begin
      spi_clk = 1'b0;
      spi_cs_n = 1'b1;
      dq_in = 4'hF;
      drove = 1'b0;
   end
   // opcode, address and data msb first on rising edges
   // select rises right after the last bit, any point of a read
   task automatic frame(input logic [39:0] tx, input int nb, output logic [23:0] rx);
      int i;
      rx = 24'h0;
      drove = 1'b0;
      spi_cs_n = 1'b0;
      for (i = 0; i < nb; i++) begin
         if (quad)
            dq_in = (i < 10) ? tx[39-4*i -: 4] : ~dq_in;
         else
            dq_in[0] = (i < 40) ? tx[39-i] : ~dq_in[0];
         #160 spi_clk = 1'b1;
         #160 rx = quad ? {rx[19:0], dq_out} : {rx[22:0], dq_out[1]};
         drove = drove | ~dq_oe_n[1];
         spi_clk = 1'b0;
      end
      #160 spi_cs_n = 1'b1;
      dq_in[0] = ~dq_in[0];
      #320;
   endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the serial flash command block
// assumes the host model drives the link and a slow memory answers fetches
`timescale 1ns/1ps
module testbench;
   logic        core_clk, rst, ext_busy, spi_clk, spi_cs_n, mem_fetch, mem_data_ready;
   logic        four_line_cmd_mode, busy_cycle_flag, write_unlock_latch, drove, otp_mode;
   logic        tgl = 1'b0;
   logic [3:0]  dq_in, dq_out, dq_oe_n;
   logic [23:0] mem_addr, rx;
   logic [1:0]  cfg_wrap_len, cfg_drive, c;
   int          mismatches, checks_done, i;
   wire [7:0]   mem_data = mem_addr[7:0] ^ 8'hA5;
   wire         mem_data_valid = mem_fetch & tgl;
   sfc_top #(.WR_CYCLES(400)) i_dut (.core_clk(core_clk), .rst(rst), .ce(1'b1),
      .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .otp_mode(otp_mode), .ext_busy(ext_busy), .mem_addr(mem_addr),
      .mem_fetch(mem_fetch), .mem_data(mem_data), .mem_data_valid(mem_data_valid),
      .mem_data_ready(mem_data_ready), .cfg_wrap_len(cfg_wrap_len), .cfg_drive(cfg_drive),
      .four_line_cmd_mode(four_line_cmd_mode), .busy_cycle_flag(busy_cycle_flag),
      .write_unlock_latch(write_unlock_latch));
   sfc_host_model i_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .dq_in(dq_in),
      .drove(drove), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // memory answers every other cycle
   always @(negedge core_clk) tgl <= ~tgl;
   task automatic chk(input string n, input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %0s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic x(input logic [39:0] tx, input int nb);
      @(negedge core_clk);
      i_host.frame(tx, nb, rx);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic t_cfg;
      chk("flags", {four_line_cmd_mode, busy_cycle_flag, write_unlock_latch}, 0);
      x({8'h95, 32'h0}, 16);
      chk("cfg reset", rx[7:0], 8'h00);
      for (i = 0; i < 4; i++) begin
         c = i[1:0];
         x({8'hC0, 2'b11, c, c, c, 24'h0}, 16);
         chk("wrap", cfg_wrap_len, c);
         chk("drive", cfg_drive, c);
         x({8'h95, 32'h0}, 16);
         chk("cfg", rx[7:0], {2'b00, c, c, c});
      end
      $display("test cfg done");
   endtask
   task automatic t_status;
      x({8'h01, 8'h00, 24'h0}, 16);
      chk("locked busy", busy_cycle_flag, 0);
      x({8'h06, 32'h0}, 8);
      chk("latch", write_unlock_latch, 1);
      x({8'h01, 8'h00, 24'h0}, 15);
      chk("short busy", busy_cycle_flag, 0);
      x({8'h01, 8'hFF, 24'h0}, 16);
      chk("busy", busy_cycle_flag, 1);
      x({8'h95, 32'h0}, 16);
      chk("cfg in busy", rx[7:0], 8'h3F);
      x({8'h05, 32'h0}, 16);
      chk("status in busy", rx[7:0], 8'hFF);
      for (i = 0; i < 1000 && busy_cycle_flag !== 1'b0; i++) @(negedge core_clk);
      chk("busy end", {busy_cycle_flag, write_unlock_latch}, 0);
      x({8'h05, 32'h0}, 16);
      chk("status", rx[7:0], 8'hFC);
      otp_mode = 1'b1;
      x({8'h06, 32'h0}, 8);
      x({8'h01, 8'h04, 24'h0}, 16);
      x({8'h05, 32'h0}, 16);
      chk("otp status", rx[7:0], 8'h07);
      for (i = 0; i < 1000 && busy_cycle_flag !== 1'b0; i++) @(negedge core_clk);
      otp_mode = 1'b0;
      chk("otp end", busy_cycle_flag, 0);
      $display("test status done");
   endtask
   task automatic t_read;
      x({8'h03, 24'hFFFFFE, 8'h00}, 56);
      chk("read", rx, 24'h5B5AA5);
      chk("release", dq_oe_n, 4'hF);
      x({8'h0B, 24'h000010, 8'h00}, 64);
      chk("fast read", rx, 24'hB5B4B7);
      ext_busy = 1'b1;
      x({8'h0B, 24'h000010, 8'h00}, 64);
      chk("busy read", drove, 0);
      ext_busy = 1'b0;
      $display("test read done");
   endtask
   task automatic t_quad;
      x({8'h38, 32'h0}, 8);
      chk("quad on", four_line_cmd_mode, 1);
      i_host.quad = 1'b1;
      x({8'hC0, 8'h10, 24'h0}, 4);
      x({8'h0B, 24'h000020, 8'h00}, 18);
      chk("quad read", rx, 24'h858487);
      x({8'hFF, 32'h0}, 2);
      i_host.quad = 1'b0;
      chk("quad off", four_line_cmd_mode, 0);
      $display("test quad done");
   endtask
   initial begin
      mismatches = 0;
      checks_done = 0;
      ext_busy = 1'b0;
      otp_mode = 1'b0;
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      t_cfg;
      t_status;
      t_read;
      t_quad;
      test_done;
   end
   initial begin
      #1000000;
      mismatches++;
      test_done;
   end
endmodule
